// ==== hdl/t1fm_pkg.sv ====
`default_nettype none
package t1fm_pkg;

   typedef enum logic [1:0] {
      T1FM_SF  = 2'h0,
      T1FM_ESF = 2'h1,
      T1FM_DM  = 2'h2,
      T1FM_SLC = 2'h3
   } t1fm_fmt_t;

   // One received bit with the synchronizer's view of it
   typedef struct packed {
      logic       bit_valid;
      logic       bit_val;
      logic       f_slot;
      logic       mf_start;
      logic       oof;
      logic       mimic;
      logic       align_found;
      logic [7:0] align_pos;
      t1fm_fmt_t  format;
   } t1fm_rx_t;

   typedef struct packed {
      logic [10:0] conc;
      logic [2:0]  maint;
      logic [3:0]  sw;
      logic [1:0]  alarm;
   } t1fm_ovh_t;

   // Register offsets
   localparam logic [7:0] ADDR_STATUS   = 8'h4F;
   localparam logic [7:0] ADDR_LOSS_EN  = 8'h50;
   localparam logic [7:0] ADDR_ERR_EN   = 8'h51;
   localparam logic [7:0] ADDR_LOSS_FLG = 8'h52;
   localparam logic [7:0] ADDR_ERR_FLG  = 8'h53;
   localparam logic [7:0] ADDR_CONC_LO  = 8'h56;
   localparam logic [7:0] ADDR_MNT_CHI  = 8'h57;
   localparam logic [7:0] ADDR_SW_ALM   = 8'h58;
   localparam logic [7:0] ADDR_OVH_CTL  = 8'h5C;
   localparam logic [7:0] ADDR_OVH_FLG  = 8'h5D;

   // Field positions
   localparam int BIT_OOF       = 0;
   localparam int BIT_MIMIC     = 4;
   localparam int BIT_EXCRC     = 5;
   localparam int BIT_FSTART    = 4;
   localparam int BIT_SEVERE    = 3;
   localparam int BIT_CRC       = 2;
   localparam int BIT_FBIT      = 1;
   localparam int BIT_ALIGN     = 0;
   localparam int BIT_DEBOUNCE  = 4;
   localparam int BIT_ALARM_CH  = 3;
   localparam int BIT_SWITCH_CH = 2;
   localparam int BIT_MAINT_CH  = 1;
   localparam int BIT_CONC_CH   = 0;

   // Reset values
   localparam logic       RST_OOF = 1'b1;
   localparam logic [7:0] RST_REG = 8'h00;

   // Expected framing patterns, bit i belongs to the (i+1)-th slot
   localparam logic [5:0]  SF_FS_PAT    = 6'h1C;
   localparam logic [5:0]  ESF_FAS_PAT  = 6'h34;
   localparam logic [10:0] SLC_FS_PAT   = 11'h638;
   localparam logic        SLC_FS_LAST  = 1'b0;
   localparam logic [6:0]  SLC_LAST_FRM = 7'h48;
   localparam logic [6:0]  SF_WIN2_FRM  = 7'h07;

   // SLC-96 overhead slots in the Fs data frames, counted from frame 24
   localparam int OVH_FIRST_N = 12;
   localparam int OVH_SLOTS   = 24;
   localparam int OVH_C_POS   = 0;
   localparam int OVH_M_POS   = 12;
   localparam int OVH_A_POS   = 15;
   localparam int OVH_S_POS   = 17;

   // Excessive CRC window
   localparam int          CLK_HZ         = 125_000_000;
   localparam int          EXCRC_WIN_S    = 1;
   localparam int          EXCRC_WIN_CYC  = EXCRC_WIN_S * CLK_HZ;
   localparam logic [8:0]  EXCRC_LIMIT    = 9'h13F;

   localparam logic [5:0]  CRC6_POLY_LOW  = 6'h03;

endpackage : t1fm_pkg
`default_nettype wire

// ==== hdl/t1fm_crc6.sv ====
`default_nettype none
module t1fm_crc6
   import t1fm_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       en,
   input  wire logic       init,
   input  wire logic       din,
   output logic      [5:0] crc
);

   typedef struct packed {
      logic [5:0] crc;
   } t1fm_crc_st_t;

   t1fm_crc_st_t s_q;
   t1fm_crc_st_t s_d;

   // Serial CRC-6, restart on the first bit of a multiframe
   always_comb
   begin
      logic [5:0] base;
      logic       fb;
      base = init ? 6'h00 : s_q.crc;
      fb   = din ^ base[5];
      s_d  = s_q;
      if (en)
      begin
         s_d.crc = {base[4:0], 1'b0} ^ (fb ? CRC6_POLY_LOW : 6'h00);
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign crc = s_q.crc;

endmodule // t1fm_crc6
`default_nettype wire

// ==== hdl/t1fm_monitor.sv ====
`default_nettype none
module t1fm_monitor
   import t1fm_pkg::*;
#(
   parameter int SEC_CYCLES = EXCRC_WIN_CYC
)
(
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire t1fm_rx_t   rx,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            irq_req,
   output t1fm_ovh_t       ovh_fields
);

   localparam int SECW = $clog2(SEC_CYCLES);

   if (SEC_CYCLES < 2)
   begin : g_bad_window
      $error("SEC_CYCLES must be at least 2");
   end

   typedef struct packed {
      logic                 out_of_frame_state;
      logic [7:0]           align_pos;
      logic                 align_held;
      logic [6:0]           frm;
      logic [1:0]           sev_cnt;
      logic [8:0]           crc_cnt;
      logic [SECW-1:0]      sec_cnt;
      logic [5:0]           crc_prev;
      logic                 crc_prev_ok;
      logic                 mf_seen;
      logic [5:0]           crc_rx;
      logic [OVH_SLOTS-1:0] fs_raw;
      logic                 slc_full;
      t1fm_ovh_t            ovh;
      t1fm_ovh_t            ovh_prev;
      logic                 frame_loss_change_irq_en;
      logic [4:0]           err_en;
      logic [3:0]           ovh_en;
      logic                 overhead_debounce_en;
      logic                 frame_loss_change_flag;
      logic                 false_pattern_flag;
      logic                 excessive_crc_flag;
      logic [4:0]           err_flags;
      logic [3:0]           ovh_flags;
      logic [7:0]           rdata;
   } t1fm_st_t;

   t1fm_st_t   s_q;
   t1fm_st_t   s_d;
   logic [5:0] crc_calc;
   logic       crc_en;
   logic       crc_init;

   // Sticky flag: set wins over a write-one clear
   function automatic logic [7:0] w1c(input logic [7:0] q, input logic [7:0] set,
                                      input logic [7:0] clr);
      return (q & ~clr) | set;
   endfunction

   // Expected framing bit for the frame number in the given format
   function automatic logic exp_fbit(input t1fm_fmt_t fmt, input logic [6:0] frm);
      logic [6:0] half;
      half = frm >> 1;
      if (frm[0])
      begin
         return ~frm[1];
      end
      else if (fmt == T1FM_ESF)
      begin
         return ESF_FAS_PAT[3'((frm >> 2) - 7'h01)];
      end
      else if (fmt == T1FM_SLC)
      begin
         if (half == 7'h24)
         begin
            return SLC_FS_LAST;
         end
         return SLC_FS_PAT[4'(half - 7'h01)];
      end
      return SF_FS_PAT[3'(half - 7'h01)];
   endfunction

   // Whether the framing bit of this frame is checked in the given format
   function automatic logic fbit_checked(input t1fm_fmt_t fmt, input logic [6:0] frm);
      logic [6:0] half;
      half = frm >> 1;
      unique case (fmt)
         T1FM_SF, T1FM_DM: return 1'b1;
         T1FM_ESF:         return frm[1:0] == 2'h0;
         T1FM_SLC:         return frm[0] || (half > 7'h00 && half < 7'h0C) || half == 7'h24;
      endcase
   endfunction

   assign crc_en   = rx.bit_valid && rx.format == T1FM_ESF;
   assign crc_init = rx.f_slot && rx.mf_start;

   t1fm_crc6 u_crc6
   (
      .clock (clock),
      .reset (reset),
      .en    (crc_en),
      .init  (crc_init),
      .din   (rx.f_slot | rx.bit_val),
      .crc   (crc_calc)
   );

   always_comb
   begin
      logic       fbit;
      logic       insync;
      logic       ferr;
      logic       win_start;
      logic       crc_err;
      logic [6:0] frm_n;
      logic [6:0] half;
      logic [7:0] set_loss;
      logic [7:0] set_err;
      logic [7:0] set_ovh;
      logic [7:0] clr_loss;
      logic [7:0] clr_err;
      logic [7:0] clr_ovh;
      logic [7:0] loss_n;
      t1fm_ovh_t  nw;
      fbit      = rx.bit_valid && rx.f_slot;
      insync    = !rx.oof;
      ferr      = 1'b0;
      win_start = 1'b0;
      crc_err   = 1'b0;
      frm_n     = s_q.frm;
      half      = 7'h00;
      set_loss  = 8'h00;
      set_err   = 8'h00;
      set_ovh   = 8'h00;
      clr_loss  = 8'h00;
      clr_err   = 8'h00;
      clr_ovh   = 8'h00;
      loss_n    = 8'h00;
      nw        = s_q.ovh;
      s_d       = s_q;

      s_d.out_of_frame_state = rx.oof;
      if (rx.oof != s_q.out_of_frame_state)
      begin
         set_loss[BIT_OOF] = 1'b1;
      end

      if (rx.mimic && (rx.format == T1FM_SF || rx.format == T1FM_ESF))
      begin
         set_loss[BIT_MIMIC] = 1'b1;
      end

      if (rx.align_found)
      begin
         if (s_q.align_held && rx.align_pos != s_q.align_pos)
         begin
            set_err[BIT_ALIGN] = 1'b1;
         end
         s_d.align_pos  = rx.align_pos;
         s_d.align_held = 1'b1;
      end

      if (fbit)
      begin
         frm_n   = rx.mf_start ? 7'h01 : 7'(s_q.frm + 7'h01);
         s_d.frm = frm_n;
         half    = frm_n >> 1;
         if (insync)
         begin
            set_err[BIT_FSTART] = 1'b1;
            if (fbit_checked(rx.format, frm_n) && rx.bit_val != exp_fbit(rx.format, frm_n))
            begin
               ferr              = 1'b1;
               set_err[BIT_FBIT] = 1'b1;
            end
         end
         // Fixed severe-error windows
         win_start = rx.mf_start
                   || ((rx.format == T1FM_SF || rx.format == T1FM_DM) && frm_n == SF_WIN2_FRM);
         if (rx.format != T1FM_SLC)
         begin
            if (ferr && (rx.format == T1FM_ESF || frm_n[0]))
            begin
               s_d.sev_cnt = win_start ? 2'h1 : (s_q.sev_cnt == 2'h2 ? 2'h2 : 2'(s_q.sev_cnt + 2'h1));
               if (!win_start && s_q.sev_cnt == 2'h1)
               begin
                  set_err[BIT_SEVERE] = 1'b1;
               end
            end
            else if (win_start)
            begin
               s_d.sev_cnt = 2'h0;
            end
         end

         // CRC-6 of previous multiframe against bits carried in this one
         if (rx.format == T1FM_ESF)
         begin
            if (rx.mf_start)
            begin
               if (insync && s_q.crc_prev_ok && s_q.crc_rx != s_q.crc_prev)
               begin
                  crc_err          = 1'b1;
                  set_err[BIT_CRC] = 1'b1;
               end
               s_d.crc_prev    = crc_calc;
               s_d.crc_prev_ok = s_q.mf_seen && insync;
               s_d.mf_seen     = insync;
            end
            if (frm_n[1:0] == 2'h2)
            begin
               s_d.crc_rx = {s_q.crc_rx[4:0], rx.bit_val};
            end
         end

         // SLC-96 overhead gathering
         if (rx.format == T1FM_SLC && !frm_n[0] && half >= 7'(OVH_FIRST_N)
             && half < 7'(OVH_FIRST_N + OVH_SLOTS))
         begin
            s_d.fs_raw[5'(half - 7'(OVH_FIRST_N))] = rx.bit_val;
         end
         if (rx.format == T1FM_SLC && rx.mf_start && insync && s_q.slc_full)
         begin
            nw.conc  = s_q.fs_raw[OVH_C_POS +: 11];
            nw.maint = s_q.fs_raw[OVH_M_POS +: 3];
            nw.alarm = s_q.fs_raw[OVH_A_POS +: 2];
            nw.sw    = s_q.fs_raw[OVH_S_POS +: 4];
            s_d.ovh_prev = nw;
            if (!s_q.overhead_debounce_en || nw.conc == s_q.ovh_prev.conc)
            begin
               s_d.ovh.conc = nw.conc;
            end
            if (!s_q.overhead_debounce_en || nw.maint == s_q.ovh_prev.maint)
            begin
               s_d.ovh.maint = nw.maint;
            end
            if (!s_q.overhead_debounce_en || nw.sw == s_q.ovh_prev.sw)
            begin
               s_d.ovh.sw = nw.sw;
            end
            if (!s_q.overhead_debounce_en || nw.alarm == s_q.ovh_prev.alarm)
            begin
               s_d.ovh.alarm = nw.alarm;
            end
         end
         if (rx.mf_start)
         begin
            s_d.slc_full = insync && rx.format == T1FM_SLC;
         end
      end
      if (rx.oof)
      begin
         s_d.slc_full = 1'b0;
      end

      set_ovh[BIT_CONC_CH]   = s_d.ovh.conc != s_q.ovh.conc;
      set_ovh[BIT_MAINT_CH]  = s_d.ovh.maint != s_q.ovh.maint;
      set_ovh[BIT_SWITCH_CH] = s_d.ovh.sw != s_q.ovh.sw;
      set_ovh[BIT_ALARM_CH]  = s_d.ovh.alarm != s_q.ovh.alarm;

      // One-second windows of CRC error counting
      if (s_q.sec_cnt == SECW'(SEC_CYCLES - 1))
      begin
         s_d.sec_cnt = '0;
         s_d.crc_cnt = crc_err ? 9'h001 : 9'h000;
      end
      else
      begin
         s_d.sec_cnt = SECW'(s_q.sec_cnt + 1'b1);
         if (crc_err && s_q.crc_cnt != 9'h1FF)
         begin
            s_d.crc_cnt = 9'(s_q.crc_cnt + 9'h001);
         end
         if (crc_err && s_q.crc_cnt == EXCRC_LIMIT)
         begin
            set_loss[BIT_EXCRC] = 1'b1;
         end
      end

      // Register writes
      clr_loss = (reg_wr && reg_addr == ADDR_LOSS_FLG) ? reg_wdata : 8'h00;
      clr_err  = (reg_wr && reg_addr == ADDR_ERR_FLG) ? reg_wdata : 8'h00;
      clr_ovh  = (reg_wr && reg_addr == ADDR_OVH_FLG) ? reg_wdata : 8'h00;
      if (reg_wr && reg_addr == ADDR_LOSS_EN)
      begin
         s_d.frame_loss_change_irq_en = reg_wdata[BIT_OOF];
      end
      if (reg_wr && reg_addr == ADDR_ERR_EN)
      begin
         s_d.err_en = reg_wdata[4:0];
      end
      if (reg_wr && reg_addr == ADDR_OVH_CTL)
      begin
         s_d.overhead_debounce_en = reg_wdata[BIT_DEBOUNCE];
         s_d.ovh_en               = reg_wdata[3:0];
      end
      loss_n = w1c({2'h0, s_q.excessive_crc_flag, s_q.false_pattern_flag, 3'h0,
                    s_q.frame_loss_change_flag}, set_loss, clr_loss);
      s_d.frame_loss_change_flag = loss_n[BIT_OOF];
      s_d.false_pattern_flag     = loss_n[BIT_MIMIC];
      s_d.excessive_crc_flag     = loss_n[BIT_EXCRC];
      s_d.err_flags = 5'(w1c({3'h0, s_q.err_flags}, set_err, clr_err));
      s_d.ovh_flags = 4'(w1c({4'h0, s_q.ovh_flags}, set_ovh, clr_ovh));

      // Register reads, data valid in the following cycle only
      s_d.rdata = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_STATUS:   s_d.rdata = {7'h00, s_q.out_of_frame_state};
            ADDR_LOSS_EN:  s_d.rdata = {7'h00, s_q.frame_loss_change_irq_en};
            ADDR_ERR_EN:   s_d.rdata = {3'h0, s_q.err_en};
            ADDR_LOSS_FLG: s_d.rdata = {2'h0, s_q.excessive_crc_flag, s_q.false_pattern_flag,
                                        3'h0, s_q.frame_loss_change_flag};
            ADDR_ERR_FLG:  s_d.rdata = {3'h0, s_q.err_flags};
            ADDR_CONC_LO:  s_d.rdata = s_q.ovh.conc[7:0];
            ADDR_MNT_CHI:  s_d.rdata = {2'h0, s_q.ovh.maint, s_q.ovh.conc[10:8]};
            ADDR_SW_ALM:   s_d.rdata = {2'h0, s_q.ovh.sw, s_q.ovh.alarm};
            ADDR_OVH_CTL:  s_d.rdata = {3'h0, s_q.overhead_debounce_en, s_q.ovh_en};
            ADDR_OVH_FLG:  s_d.rdata = {4'h0, s_q.ovh_flags};
            default:       s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         s_q                    <= '0;
         s_q.out_of_frame_state <= RST_OOF;
         s_q.rdata              <= RST_REG;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign reg_rdata  = s_q.rdata;
   assign ovh_fields = s_q.ovh;
   assign irq_req    = (s_q.frame_loss_change_flag && s_q.frame_loss_change_irq_en)
                     || |(s_q.err_flags & s_q.err_en)
                     || |(s_q.ovh_flags & s_q.ovh_en);

endmodule // t1fm_monitor
`default_nettype wire

// ==== test/t1fm_rx_model.sv ====
`default_nettype none
module t1fm_rx_model
   import t1fm_pkg::*;
(
   input  wire logic clock,
   output var t1fm_rx_t rx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial rx = '{oof: 1'b1, format: T1FM_SF, default: '0};
   // One bit, then the line shows its inverse
   task automatic put(input logic v, input logic f, input logic mf);
      @(posedge clock);
      rx.bit_valid <= 1'b1;
      rx.bit_val   <= v;
      rx.f_slot    <= f;
      rx.mf_start  <= mf;
      @(posedge clock);
      rx.bit_valid <= 1'b0;
      rx.bit_val   <= ~v;
      rx.f_slot    <= 1'b0;
      rx.mf_start  <= 1'b0;
   endtask
   // Framing bit and one payload bit
   task automatic frame(input logic v, input logic mf);
      put(v, 1'b1, mf);
      put(1'b0, 1'b0, 1'b0);
   endtask
   task automatic link(input logic o, input t1fm_fmt_t f);
      @(posedge clock);
      rx.oof    <= o;
      rx.format <= f;
   endtask
   // Mimic or alignment report
   task automatic ev(input logic m, input logic a, input logic [7:0] p);
      @(posedge clock);
      rx.mimic       <= m;
      rx.align_found <= a;
      rx.align_pos   <= p;
      @(posedge clock);
      rx.mimic       <= 1'b0;
      rx.align_found <= 1'b0;
   endtask
endmodule // t1fm_rx_model
`default_nettype wire

// ==== test/t1fm_monitor_chk.sv ====
`default_nettype none
module t1fm_monitor_chk
   import t1fm_pkg::*;
#(
   parameter int SEC_CYCLES = EXCRC_WIN_CYC
)
(
   input wire logic       clock,
   input wire logic       reset,
   input wire t1fm_rx_t   rx,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       irq_req,
   input wire t1fm_ovh_t  ovh_fields
);
   logic [7:0] en_loss_q;
   logic [7:0] en_err_q;
   logic [7:0] en_ovh_q;
   logic       no_en;
   logic       mf_slc;
   // Shadow of the enable registers
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         en_loss_q <= 8'h00;
         en_err_q  <= 8'h00;
         en_ovh_q  <= 8'h00;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_LOSS_EN) en_loss_q <= reg_wdata & 8'h01;
         if (reg_addr == ADDR_ERR_EN) en_err_q <= reg_wdata & 8'h1F;
         if (reg_addr == ADDR_OVH_CTL) en_ovh_q <= reg_wdata & 8'h0F;
      end
   end
   assign no_en  = (en_loss_q | en_err_q | en_ovh_q) == 8'h00;
   assign mf_slc = rx.bit_valid && rx.f_slot && rx.mf_start && rx.format == T1FM_SLC;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   AST_OOF_READ: assert property (reg_rd && reg_addr == ADDR_STATUS
      |=> reg_rdata == {7'h00, $past(rx.oof, 2)}) else $error("status bit mismatch");
   AST_IRQ_GATED: assert property (no_en |-> !irq_req)
      else $error("request without enable");
   AST_IRQ_CLEARED: assert property (reg_wr && reg_addr == ADDR_ERR_FLG
      && reg_wdata == 8'hFF && en_loss_q[0] == 1'b0 && en_ovh_q == 8'h00
      && !rx.bit_valid && !rx.align_found |=> !irq_req) else $error("request after clear");
   AST_FSTART: assert property (rx.bit_valid && rx.f_slot && !rx.oof
      && en_err_q[BIT_FSTART] |=> irq_req) else $error("frame start not flagged");
   AST_OOF_CHANGE: assert property ($changed(rx.oof) && en_loss_q[0]
      |-> ##[1:2] irq_req) else $error("status change not flagged");
   AST_OVH_FROZEN: assert property (rx.oof && $past(rx.oof)
      |=> $stable(ovh_fields)) else $error("overhead moved out of sync");
   AST_OVH_AT_MF: assert property ($changed(ovh_fields)
      |-> $past(mf_slc) || $past(mf_slc, 2)) else $error("overhead moved off edge");
   AST_CONC_LO: assert property (reg_rd && reg_addr == ADDR_CONC_LO
      ##1 $stable(ovh_fields) |-> reg_rdata == ovh_fields.conc[7:0])
      else $error("concentrator low mismatch");
   AST_MNT_HI: assert property (reg_rd && reg_addr == ADDR_MNT_CHI
      ##1 $stable(ovh_fields) |-> reg_rdata == {2'b00, ovh_fields.maint, ovh_fields.conc[10:8]})
      else $error("maintenance register mismatch");
   C_SLC: cover property (mf_slc && !rx.oof);
   C_OVH: cover property ($changed(ovh_fields));
   C_IRQ: cover property ($rose(irq_req));
endmodule // t1fm_monitor_chk
bind t1fm_monitor t1fm_monitor_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.clock, .reset, .rx,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_req, .ovh_fields);
`default_nettype wire

// ==== test/t1fm_monitor_bench.sv ====
`default_nettype none
module t1fm_monitor_bench
   import t1fm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam t1fm_ovh_t OV1 = 20'h6D5B6;
   localparam t1fm_ovh_t OV2 = 20'h92A49;
   logic       clock     = 1'b0;
   logic       reset     = 1'b1;
   t1fm_rx_t   rx;
   logic [7:0] reg_addr  = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic [7:0] reg_rdata;
   logic       irq_req;
   t1fm_ovh_t  ovh_fields;
   int         mismatches = 0;
   int         n_compared = 0;
   logic [7:0] zero_regs [10] = '{ADDR_LOSS_EN, ADDR_ERR_EN, ADDR_LOSS_FLG, ADDR_ERR_FLG,
      ADDR_CONC_LO, ADDR_MNT_CHI, ADDR_SW_ALM, ADDR_OVH_CTL, ADDR_OVH_FLG, 8'h00};
   always #4 clock = ~clock;
   t1fm_rx_model rxm (.clock, .rx);
   t1fm_monitor #(.SEC_CYCLES(200)) dut (.clock, .reset, .rx, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .irq_req, .ovh_fields);
   task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
   endtask
   task automatic rd_ovh(input t1fm_ovh_t o);
      rd(ADDR_CONC_LO, o.conc[7:0], "conc low");
      rd(ADDR_MNT_CHI, {2'b00, o.maint, o.conc[10:8]}, "maint conc high");
      rd(ADDR_SW_ALM, {2'b00, o.sw, o.alarm}, "switch alarm");
      chk("fields", o, ovh_fields);
   endtask
   // Expected framing bit of frame k
   function automatic logic fbit(input int k, input t1fm_ovh_t o, input logic slc);
      int n;
      n = k / 2;
      if (k % 2) return (n % 2) == 0;
      if (!slc) return SF_FS_PAT[n - 1];
      if (n <= 11) return SLC_FS_PAT[n - 1];
      if (n <= 22) return o.conc[n - 12];
      if (n == 23) return 1'b0;
      if (n <= 26) return o.maint[n - 24];
      if (n <= 28) return o.alarm[n - 27];
      if (n <= 32) return o.sw[n - 29];
      return SLC_FS_LAST;
   endfunction
   // Frames 2..nf, then frame 1 of the next superframe
   task automatic send_sf(input int nf, input t1fm_ovh_t o, input logic [12:0] err);
      for (int k = 1; k <= nf; k++)
         rxm.frame(fbit(k % nf + 1, o, nf == 72) ^ (k < 12 && err[k + 1]), k == nf);
   endtask
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clock);
      mismatches++;
      test_done();
   end
   initial
   begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      rd(ADDR_STATUS, 8'h01, "status reset");
      foreach (zero_regs[i])
         rd(zero_regs[i], 8'h00, "reset value");
      wr(ADDR_ERR_EN, 8'hFF);
      rd(ADDR_ERR_EN, 8'h1F, "error enables");
      wr(ADDR_LOSS_EN, 8'hFF);
      rd(ADDR_LOSS_EN, 8'h01, "loss enable");
      wr(ADDR_OVH_CTL, 8'h0F);
      $display("done: registers");
      rxm.link(1'b0, T1FM_SF);
      repeat (2) @(posedge clock);
      rd(ADDR_STATUS, 8'h00, "status in sync");
      rd(ADDR_LOSS_FLG, 8'h01, "status change");
      chk("irq", 1'b1, irq_req);
      wr(ADDR_LOSS_FLG, 8'h00);
      rd(ADDR_LOSS_FLG, 8'h01, "write zero keeps");
      wr(ADDR_LOSS_FLG, 8'h01);
      rd(ADDR_LOSS_FLG, 8'h00, "write one clears");
      chk("irq", 1'b0, irq_req);
      rxm.frame(1'b1, 1'b1);
      send_sf(12, OV1, 13'h000);
      rd(ADDR_ERR_FLG, 8'h10, "clean superframe");
      wr(ADDR_ERR_FLG, 8'hFF);
      send_sf(12, OV1, 13'h028);
      rd(ADDR_ERR_FLG, 8'h1A, "two framing errors");
      wr(ADDR_ERR_EN, 8'h00);
      chk("irq", 1'b0, irq_req);
      wr(ADDR_ERR_FLG, 8'hFF);
      $display("done: superframe");
      rxm.ev(1'b0, 1'b1, 8'h05);
      rxm.ev(1'b0, 1'b1, 8'h05);
      rd(ADDR_ERR_FLG, 8'h00, "same position");
      rxm.ev(1'b0, 1'b1, 8'h09);
      rd(ADDR_ERR_FLG, 8'h01, "new position");
      rxm.ev(1'b1, 1'b0, 8'h00);
      rd(ADDR_LOSS_FLG, 8'h10, "mimic");
      wr(ADDR_LOSS_FLG, 8'hFF);
      wr(ADDR_ERR_FLG, 8'hFF);
      rxm.link(1'b1, T1FM_SLC);
      rxm.ev(1'b1, 1'b0, 8'h00);
      send_sf(12, OV1, 13'h028);
      rd(ADDR_ERR_FLG, 8'h00, "ignored out of sync");
      rd(ADDR_LOSS_FLG, 8'h01, "loss, no mimic");
      wr(ADDR_LOSS_FLG, 8'hFF);
      $display("done: events");
      rxm.link(1'b0, T1FM_SLC);
      rxm.frame(1'b1, 1'b1);
      wr(ADDR_LOSS_FLG, 8'hFF);
      send_sf(72, OV1, 13'h000);
      rd_ovh(OV1);
      rd(ADDR_OVH_FLG, 8'h0F, "field changes");
      chk("irq", 1'b1, irq_req);
      wr(ADDR_OVH_FLG, 8'hFF);
      chk("irq", 1'b0, irq_req);
      wr(ADDR_OVH_CTL, 8'h1F);
      rd(ADDR_OVH_CTL, 8'h1F, "debounce on");
      send_sf(72, OV2, 13'h000);
      rd_ovh(OV1);
      send_sf(72, OV2, 13'h000);
      rd_ovh(OV2);
      rd(ADDR_OVH_FLG, 8'h0F, "debounced changes");
      rxm.link(1'b1, T1FM_SLC);
      send_sf(72, OV1, 13'h000);
      send_sf(72, OV1, 13'h000);
      rd_ovh(OV2);
      $display("done: overhead");
      wr(ADDR_LOSS_EN, 8'h00);
      wr(ADDR_OVH_CTL, 8'h00);
      wr(ADDR_ERR_EN, 8'hFF);
      chk("irq frame start", 1'b1, irq_req);
      wr(ADDR_ERR_FLG, 8'hFF);
      chk("irq all cleared", 1'b0, irq_req);
      rxm.link(1'b0, T1FM_DM);
      rxm.frame(1'b1, 1'b1);
      wr(ADDR_ERR_FLG, 8'hFF);
      send_sf(12, OV1, 13'h028);
      rd(ADDR_ERR_FLG, 8'h1A, "digital mux errors");
      $display("done: digital mux");
      test_done();
   end
endmodule // t1fm_monitor_bench
`default_nettype wire
